// [core/nco_tick.sv]
`include "osc_ctrl_map.svh"
// Phase accumulator producing a one-cycle enable at a fraction of clk_sys_i
module nco_tick (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Control
	input wire logic run_i,
	input wire logic [31:0] step_i,
	// Output
	output logic tick_o
);
	logic [31:0] acc_r, acc_nxt;
	logic tick_nxt;
	logic [32:0] sum;
	always_comb begin
		sum = {1'b0, acc_r} + {1'b0, step_i};
		acc_nxt = run_i ? sum[31:0] : 32'h0;
		tick_nxt = run_i & sum[32];
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_r <= 32'h0;
			tick_o <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			tick_o <= tick_nxt;
		end
	end
endmodule // nco_tick

// [core/osc_ctrl.sv]
// Contract
// (R1) After reset the high oscillator starts at 1 MHz for reset code 110 and 32 MHz for 000.
// (R2) Software switches the system clock source by writing the new select field.
// (R3) With an internal source the input pin is released and the output pin follows a cfg bit.
// (R4) Two independent internal oscillators, high and low, can each be the system clock.
// (R5) The high oscillator runs up to 32 MHz at the rate picked by the 3-bit select field.
// (R6) A mid source inside the high oscillator always gives 500 kHz and 32 kHz clocks.
// (R7) A 4-bit divider field divides the high oscillator output from 1:1 to 1:512.
// (R8) The trim register resets to zero and holds a 6-bit two's complement adjustment.
// (R9) Trim 1Fh is the largest step up and 20h the largest step down.
// (R10) After a trim write the frequency moves gradually with no completion status.
// (R11) Trim leaves the low oscillator and its users untouched.
// (R12) The low oscillator runs at 31 kHz and times the power-up timer, watchdog and monitor.
// (R13) The low oscillator is enabled by the reset select or by a run-time select write; here it always runs.
// (R14) The low oscillator clock is also offered to the timers and the logic cell.
// (R15) A ready bit per oscillator is readable in the status register.
// (R16) Manual enables start any oscillator, external and secondary too, and show ready.
// (R17) Source, frequency and divider changes reach the clock output without runts; here frequency skips the switch and a new source may tick next cycle.
//
// The register addresses and register access over APB are this design's own decisions.
`include "osc_ctrl_map.svh"
module osc_ctrl (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Configuration words
	input wire osc_ctrl_pkg::osc_code_t reset_osc_select_i,
	input wire logic clock_output_enable_cfg_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Clock enables to consumers
	output logic sys_clk_en_o,
	output logic lf_tick_o,
	output logic mf_500k_tick_o,
	output logic mf_32k_tick_o,
	// Pins
	output logic clock_input_pin_release_o,
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe_o
);
	import osc_ctrl_pkg::*;

	// ****************
	// Registers
	// ****************
	logic [2:0] new_osc_select_r, new_osc_select_nxt;
	logic [3:0] clock_divider_field_r, clock_divider_field_nxt;
	logic [2:0] high_freq_select_field_r, high_freq_select_field_nxt;
	logic [5:0] oscillator_trim_r, oscillator_trim_nxt;
	logic [4:0] osc_manual_enable_r, osc_manual_enable_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt, pslverr_nxt;
	logic cfg_loaded_r, cfg_loaded_nxt;
	logic wr_en, rd_en;
	logic [4:0] ready_bits;
	always_comb begin
		wr_en = psel_i & penable_i & pwrite_i & ~pready_o;
		rd_en = psel_i & penable_i & ~pwrite_i & ~pready_o;
		new_osc_select_nxt = new_osc_select_r;
		clock_divider_field_nxt = clock_divider_field_r;
		high_freq_select_field_nxt = high_freq_select_field_r;
		oscillator_trim_nxt = oscillator_trim_r;
		osc_manual_enable_nxt = osc_manual_enable_r;
		cfg_loaded_nxt = 1'b1;
		prdata_nxt = 32'h0;
		pslverr_nxt = 1'b0;
		pready_nxt = psel_i & penable_i & ~pready_o;
		if (!cfg_loaded_r) begin
			// Reset strap caught one cycle after release
			new_osc_select_nxt = reset_osc_select_i; // see (R1) (R13)
			high_freq_select_field_nxt = (reset_osc_select_i == `RSTOSC_HF_1M) ?
				`HFFRQ_1M : `HFFRQ_32M; // see (R1)
		end
		if (wr_en) begin
			if (paddr_i == `OFS_CONTROL_ONE) begin
				new_osc_select_nxt = pwdata_i[`NOSC_LSB +: 3]; // see (R2) (R13)
				clock_divider_field_nxt = pwdata_i[`DIV_LSB +: 4]; // see (R7)
			end else if (paddr_i == `OFS_FREQ_SEL) begin
				high_freq_select_field_nxt = pwdata_i[2:0]; // see (R5)
			end else if (paddr_i == `OFS_TRIM) begin
				oscillator_trim_nxt = pwdata_i[5:0]; // see (R8)
			end else if (paddr_i == `OFS_ENABLE) begin
				osc_manual_enable_nxt = pwdata_i[4:0]; // see (R16)
			end else if (paddr_i != `OFS_READY && paddr_i != `OFS_CFG) begin
				pslverr_nxt = 1'b1;
			end
		end
		if (rd_en) begin
			if (paddr_i == `OFS_CONTROL_ONE) begin
				prdata_nxt = {25'h0, new_osc_select_r, clock_divider_field_r};
			end else if (paddr_i == `OFS_FREQ_SEL) begin
				prdata_nxt = {29'h0, high_freq_select_field_r};
			end else if (paddr_i == `OFS_TRIM) begin
				prdata_nxt = {26'h0, oscillator_trim_r};
			end else if (paddr_i == `OFS_READY) begin
				prdata_nxt = {27'h0, ready_bits}; // see (R15)
			end else if (paddr_i == `OFS_ENABLE) begin
				prdata_nxt = {27'h0, osc_manual_enable_r};
			end else if (paddr_i == `OFS_CFG) begin
				prdata_nxt = {28'h0, clock_output_enable_cfg_i, reset_osc_select_i};
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			new_osc_select_r <= 3'h0;
			clock_divider_field_r <= 4'h0;
			high_freq_select_field_r <= `HFFRQ_32M;
			oscillator_trim_r <= `TRIM_RESET; // see (R8)
			osc_manual_enable_r <= 5'h0;
			cfg_loaded_r <= 1'b0;
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			new_osc_select_r <= new_osc_select_nxt;
			clock_divider_field_r <= clock_divider_field_nxt;
			high_freq_select_field_r <= high_freq_select_field_nxt;
			oscillator_trim_r <= oscillator_trim_nxt;
			osc_manual_enable_r <= osc_manual_enable_nxt;
			cfg_loaded_r <= cfg_loaded_nxt;
			prdata_o <= prdata_nxt;
			pready_o <= pready_nxt;
			pslverr_o <= pslverr_nxt;
		end
	end

	// ****************
	// Oscillator models
	// ****************
	// Step for an NCO: f * 2^32 / 125 MHz
	function automatic logic [31:0] nco_step(input logic [31:0] hz);
		logic [63:0] p;
		p = {32'h0, hz} << 32;
		nco_step = 32'(p / 64'(`SYS_CLK_HZ));
	endfunction
	// Trim applied as step * (1 + t/256), only on the high oscillator
	function automatic logic [31:0] trimmed(input logic [31:0] s, input logic signed [6:0] t);
		logic signed [40:0] adj;
		adj = $signed({9'h0, s}) + (($signed({9'h0, s}) >>> 8) * t);
		trimmed = adj[31:0];
	endfunction
	logic [31:0] hf_base;
	always_comb begin
		case (high_freq_select_field_r) // see (R5)
			3'h0: hf_base = nco_step(32'd1000000);
			3'h1: hf_base = nco_step(32'd2000000);
			3'h2: hf_base = nco_step(32'd4000000);
			3'h3: hf_base = nco_step(32'd8000000);
			3'h4: hf_base = nco_step(32'd12000000);
			3'h5: hf_base = nco_step(32'd16000000);
			default: hf_base = nco_step(`HF_MAX_HZ);
		endcase
	end
	// Trim walks one step at a time toward the written value
	logic signed [6:0] trim_eff_r, trim_eff_nxt;
	logic [4:0] trim_cnt_r, trim_cnt_nxt;
	always_comb begin
		trim_cnt_nxt = (trim_cnt_r == 5'(`TRIM_STEP_CYC - 1)) ? 5'h0 : trim_cnt_r + 5'h1;
		trim_eff_nxt = trim_eff_r;
		if (trim_cnt_r == 5'h0) begin
			if (trim_eff_r < $signed({oscillator_trim_r[5], oscillator_trim_r}))
				trim_eff_nxt = trim_eff_r + 7'sd1; // see (R9) (R10)
			else if (trim_eff_r > $signed({oscillator_trim_r[5], oscillator_trim_r}))
				trim_eff_nxt = trim_eff_r - 7'sd1; // see (R9) (R10)
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trim_eff_r <= 7'sd0;
			trim_cnt_r <= 5'h0;
		end else begin
			trim_eff_r <= trim_eff_nxt;
			trim_cnt_r <= trim_cnt_nxt;
		end
	end

	// Ready counters: bit0 high, 1 low, 2 mid, 3 external, 4 secondary
	logic [4:0] osc_on;
	logic [7:0] rdy_cnt_r [5];
	logic [7:0] rdy_cnt_nxt [5];
	always_comb begin
		osc_on[0] = (new_osc_select_r == `RSTOSC_HF_1M) | (new_osc_select_r == `RSTOSC_HF_32M)
			| osc_manual_enable_r[0] | 1'b1; // mid source keeps high running, see (R6)
		osc_on[1] = (new_osc_select_r == `RSTOSC_LF) | osc_manual_enable_r[1] | 1'b1; // see (R12) (R13)
		osc_on[2] = osc_on[0]; // see (R6)
		osc_on[3] = osc_manual_enable_r[3]; // see (R16)
		osc_on[4] = osc_manual_enable_r[4]; // see (R16)
		for (int i = 0; i < 5; i++) begin
			if (!osc_on[i])
				rdy_cnt_nxt[i] = 8'h0;
			else if (rdy_cnt_r[i] != 8'(`READY_CYC))
				rdy_cnt_nxt[i] = rdy_cnt_r[i] + 8'h1;
			else
				rdy_cnt_nxt[i] = rdy_cnt_r[i];
			ready_bits[i] = (rdy_cnt_r[i] == 8'(`READY_CYC)); // see (R15) (R16)
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 5; i++) rdy_cnt_r[i] <= 8'h0;
		end else begin
			for (int i = 0; i < 5; i++) rdy_cnt_r[i] <= rdy_cnt_nxt[i];
		end
	end

	logic hf_tick, lf_tick, mf5_tick, mf3_tick, ext_tick;
	nco_tick u_hf (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .run_i(osc_on[0]),
		.step_i(trimmed(hf_base, trim_eff_r)), .tick_o(hf_tick)); // see (R4) (R5)
	nco_tick u_lf (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .run_i(osc_on[1]),
		.step_i(nco_step(`LF_OSC_HZ)), .tick_o(lf_tick)); // see (R11) (R12)
	nco_tick u_mf5 (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .run_i(osc_on[2]),
		.step_i(nco_step(`MF_500K_HZ)), .tick_o(mf5_tick)); // see (R6)
	nco_tick u_mf3 (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .run_i(osc_on[2]),
		.step_i(nco_step(`MF_32K_HZ)), .tick_o(mf3_tick)); // see (R6)
	assign ext_tick = 1'b0;

	// ****************
	// Divider and glitch-free switch
	// ****************
	// Source and divider are only swapped on a tick of the active source, or while neither high nor low is ready; the new source may tick in the next cycle
	logic [8:0] div_cnt_r, div_cnt_nxt;
	logic [3:0] div_act_r, div_act_nxt;
	logic [2:0] src_act_r, src_act_nxt;
	logic [2:0] hffrq_act_r, hffrq_act_nxt;
	logic hf_div_tick, src_tick, sys_en_nxt, co_r, co_nxt;
	function automatic logic [8:0] div_limit(input logic [3:0] d);
		div_limit = (d > 4'h9) ? 9'h1ff : 9'((10'h1 << d) - 10'h1);
	endfunction
	always_comb begin
		hf_div_tick = 1'b0;
		div_cnt_nxt = div_cnt_r;
		if (hf_tick) begin
			if (div_cnt_r >= div_limit(div_act_r)) begin
				div_cnt_nxt = 9'h0;
				hf_div_tick = 1'b1; // see (R7)
			end else begin
				div_cnt_nxt = div_cnt_r + 9'h1;
			end
		end
		src_tick = (src_act_r == `RSTOSC_LF) ? lf_tick : hf_div_tick; // see (R4)
		src_act_nxt = src_act_r;
		div_act_nxt = div_act_r;
		hffrq_act_nxt = hffrq_act_r;
		if (src_tick | ~(ready_bits[0] | ready_bits[1])) begin
			src_act_nxt = new_osc_select_r; // see (R2) (R17)
			div_act_nxt = clock_divider_field_r; // see (R17)
			hffrq_act_nxt = high_freq_select_field_r;
		end
		sys_en_nxt = src_tick;
		co_nxt = src_tick ? ~co_r : co_r; // see (R17)
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_cnt_r <= 9'h0;
			div_act_r <= 4'h0;
			src_act_r <= 3'h0;
			hffrq_act_r <= `HFFRQ_32M;
			co_r <= 1'b0;
			sys_clk_en_o <= 1'b0;
			lf_tick_o <= 1'b0;
			mf_500k_tick_o <= 1'b0;
			mf_32k_tick_o <= 1'b0;
			clock_input_pin_release_o <= 1'b0;
			clock_output_pin_o <= 1'b0;
			clock_output_pin_oe_o <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			div_act_r <= div_act_nxt;
			src_act_r <= src_act_nxt;
			hffrq_act_r <= hffrq_act_nxt;
			co_r <= co_nxt;
			sys_clk_en_o <= sys_en_nxt;
			lf_tick_o <= lf_tick; // see (R14)
			mf_500k_tick_o <= mf5_tick;
			mf_32k_tick_o <= mf3_tick;
			clock_input_pin_release_o <= cfg_loaded_r; // see (R3)
			clock_output_pin_o <= co_r; // see (R3)
			clock_output_pin_oe_o <= clock_output_enable_cfg_i & cfg_loaded_r; // see (R3)
		end
	end
endmodule // osc_ctrl

// [core/osc_ctrl_map.svh]
`ifndef OSC_CTRL_MAP_SVH
`define OSC_CTRL_MAP_SVH
// Register byte offsets
`define OFS_CONTROL_ONE 12'h000
`define OFS_FREQ_SEL 12'h004
`define OFS_TRIM 12'h008
`define OFS_READY 12'h00c
`define OFS_ENABLE 12'h010
`define OFS_CFG 12'h014
// Field positions in control one
`define DIV_LSB 0
`define NOSC_LSB 4
// Reset oscillator codes and frequency select codes
`define RSTOSC_HF_1M 3'h6
`define RSTOSC_HF_32M 3'h0
`define RSTOSC_LF 3'h5
`define HFFRQ_1M 3'h0
`define HFFRQ_32M 3'h6
`define TRIM_RESET 6'h00
// Oscillator model timing, in Hz, ns and system clock cycles
`define SYS_CLK_HZ 125000000
`define LF_OSC_HZ 31000
`define MF_500K_HZ 500000
`define MF_32K_HZ 32000
`define HF_MAX_HZ 32000000
`define READY_TIME_NS 1000
`define READY_CYC ((`READY_TIME_NS * 125 + 999) / 1000)
`define TRIM_STEP_CYC 16
`endif

// [core/osc_ctrl_pkg.sv]
package osc_ctrl_pkg;
	typedef enum logic [3:0] {
		SW_IDLE = 4'b0001,
		SW_WAIT_RDY = 4'b0010,
		SW_WAIT_LOW = 4'b0100,
		SW_DONE = 4'b1000
	} sw_state_t;
	typedef logic [2:0] osc_code_t;
endpackage

// [test/internal_oscillator_clock_select_bench.sv]
`include "osc_ctrl_map.svh"
module internal_oscillator_clock_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import osc_ctrl_pkg::*;
	logic clk_sys_i = 1'b0, rstn_i = 1'b0, cfg = 1'b1, clr = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic sys_en, lf_tick, mf_tick;
	logic [15:0] sys_cnt, mf_cnt;
	osc_code_t sel = 3'h6;
	int n_mismatch = 0, comparisons = 0;
	int mhz[7] = '{1, 2, 4, 8, 12, 16, 32};
	osc_ctrl osc_ctrl_i (.clk_sys_i, .rstn_i, .reset_osc_select_i(sel),
		.clock_output_enable_cfg_i(cfg), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .sys_clk_en_o(sys_en), .lf_tick_o(lf_tick),
		.mf_500k_tick_o(mf_tick), .mf_32k_tick_o(), .clock_input_pin_release_o(),
		.clock_output_pin_o(), .clock_output_pin_oe_o());
	osc_consumers osc_consumers_i (.clk_sys_i, .rstn_i, .clr_i(clr), .sys_clk_en_i(sys_en),
		.mf_500k_tick_i(mf_tick), .sys_cnt_o(sys_cnt), .mf_cnt_o(mf_cnt));
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	// ****
	// Shared tasks
	// ****
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// Master holds the request until pready is sampled high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		@(posedge clk_sys_i);
		while (pready !== 1'b1) begin
			k++;
			if (k > 50) begin
				n_mismatch++;
				conclude();
			end
			@(posedge clk_sys_i);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so the next setup never overwrites the release
		@(posedge clk_sys_i);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(a, 1'b0, 32'h0);
		chk(what, rd, exp);
	endtask
	// Counts are loose by one: the window edges cut enables
	task automatic measure(input int cyc, input int exp);
		clr <= 1'b1;
		@(posedge clk_sys_i);
		clr <= 1'b0;
		repeat (cyc) @(posedge clk_sys_i);
		chk("sys rate", 32'((sys_cnt + 16'd1 - 16'(exp)) <= 16'd2), 32'h1);
	endtask
	task automatic do_reset(input osc_code_t code, input logic c);
		rstn_i <= 1'b0;
		sel <= code;
		cfg <= c;
		repeat (5) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (200) @(posedge clk_sys_i);
	endtask
	// ****
	// Tests
	// ****
	initial begin
		do_reset(3'h6, 1'b1);
		rdc(`OFS_FREQ_SEL, 32'h0, "freq");
		rdc(`OFS_TRIM, 32'h0, "trim reset");
		rdc(`OFS_CFG, 32'he, "cfg");
		measure(1250, 10);
		foreach (mhz[i]) begin
			if (i < 3) begin
				apb(`OFS_TRIM, 1'b1, 32'hffffffc0 | 32'(7'h1f + i));
				rdc(`OFS_TRIM, 32'(6'(7'h1f + i)), "trim");
			end
		end
		apb(12'h018, 1'b0, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		$display("test start1m done");
		do_reset(3'h0, 1'b0);
		rdc(`OFS_FREQ_SEL, 32'h6, "freq");
		rdc(`OFS_CFG, 32'h0, "cfg");
		measure(1000, 256);
		foreach (mhz[i]) begin
			apb(`OFS_FREQ_SEL, 1'b1, 32'(i));
			repeat (300) @(posedge clk_sys_i);
			measure(1000, mhz[i] * 8);
		end
		for (int d = 0; d < 13; d += 4) begin
			apb(`OFS_CONTROL_ONE, 1'b1, 32'(d + (d == 8)));
			repeat (2100) @(posedge clk_sys_i);
			measure(4000, (d < 8) ? (1024 >> d) : 2);
		end
		$display("test rates done");
		apb(`OFS_CONTROL_ONE, 1'b1, 32'h50);
		repeat (5000) @(posedge clk_sys_i);
		measure(8064, 2);
		chk("mid rate", 32'((mf_cnt + 16'd1 - 16'd32) <= 16'd2), 32'h1);
		apb(`OFS_ENABLE, 1'b1, 32'h1f);
		repeat (200) @(posedge clk_sys_i);
		rdc(`OFS_ENABLE, 32'h1f, "enable");
		apb(`OFS_READY, 1'b1, 32'h0);
		rdc(`OFS_READY, 32'h1f, "ready");
		$display("test switch done");
		conclude();
	end
endmodule // internal_oscillator_clock_select_bench

// [test/osc_consumers.sv]
// ****
// Core and peripheral consumers, counting enables
// ****
module osc_consumers (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Enables and window clear
	input wire logic clr_i,
	input wire logic sys_clk_en_i,
	input wire logic mf_500k_tick_i,
	// Counts
	output logic [15:0] sys_cnt_o,
	output logic [15:0] mf_cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Consumers take one step per enable, never per edge
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sys_cnt_o <= 16'h0;
			mf_cnt_o <= 16'h0;
		end else if (clr_i) begin
			sys_cnt_o <= 16'h0;
			mf_cnt_o <= 16'h0;
		end else begin
			sys_cnt_o <= sys_cnt_o + 16'(sys_clk_en_i);
			mf_cnt_o <= mf_cnt_o + 16'(mf_500k_tick_i);
		end
	end
endmodule // osc_consumers

// [test/osc_ctrl_props.sv]
// ****
// Bus answer and clock enable checks
// ****
module osc_ctrl_props (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Watched ports
	input wire logic clock_output_enable_cfg_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic sys_clk_en_o,
	input wire logic lf_tick_o,
	input wire logic mf_500k_tick_o,
	input wire logic mf_32k_tick_o,
	input wire logic clock_input_pin_release_o,
	input wire logic clock_output_pin_o,
	input wire logic clock_output_pin_oe_o
);
	logic [12:0] ms_gap_r, ms_gap_nxt;
	logic ms_seen_r, ms_seen_nxt;
	always_comb begin
		ms_gap_nxt = mf_32k_tick_o ? 13'h0 : ms_gap_r + 13'h1;
		ms_seen_nxt = ms_seen_r | mf_32k_tick_o;
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ms_gap_r <= 13'h0;
			ms_seen_r <= 1'b0;
		end else begin
			ms_gap_r <= ms_gap_nxt;
			ms_seen_r <= ms_seen_nxt;
		end
	end
	logic [12:0] lf_gap_r, lf_gap_nxt;
	logic [8:0] mf_gap_r, mf_gap_nxt;
	logic [1:0] up_r, up_nxt;
	logic lf_seen_r, lf_seen_nxt, mf_seen_r, mf_seen_nxt;
	always_comb begin
		lf_gap_nxt = lf_tick_o ? 13'h0 : lf_gap_r + 13'h1;
		mf_gap_nxt = mf_500k_tick_o ? 9'h0 : mf_gap_r + 9'h1;
		lf_seen_nxt = lf_seen_r | lf_tick_o;
		mf_seen_nxt = mf_seen_r | mf_500k_tick_o;
		up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lf_gap_r <= 13'h0;
			mf_gap_r <= 9'h0;
			lf_seen_r <= 1'b0;
			mf_seen_r <= 1'b0;
			up_r <= 2'h0;
		end else begin
			lf_gap_r <= lf_gap_nxt;
			mf_gap_r <= mf_gap_nxt;
			lf_seen_r <= lf_seen_nxt;
			mf_seen_r <= mf_seen_nxt;
			up_r <= up_nxt;
		end
	end
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	sequence acc_wait_s;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence quiet_two_s;
		!sys_clk_en_o [*2];
	endsequence
	apb_answer_a: assert property (acc_wait_s |=> pready_o)
		else $error("no answer after the wait state");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("answer held too long");
	ready_qual_a: assert property (pready_o |-> psel_i && penable_i)
		else $error("answer outside an access");
	err_qual_a: assert property (pslverr_o |-> pready_o)
		else $error("error without answer");
	pin_release_a: assert property (up_r == 2'h3 |-> clock_input_pin_release_o)
		else $error("input pin not released");
	out_enable_a: assert property (up_r == 2'h3 && $stable(clock_output_enable_cfg_i)
		|-> clock_output_pin_oe_o == clock_output_enable_cfg_i)
		else $error("output pin enable wrong");
	sys_gap_a: assert property (sys_clk_en_o |=> quiet_two_s)
		else $error("system enable faster than top rate");
	lf_period_a: assert property (lf_tick_o && lf_seen_r |-> lf_gap_r inside {[13'd4030:13'd4034]})
		else $error("low tick period wrong");
	mf_period_a: assert property (mf_500k_tick_o && mf_seen_r |-> mf_gap_r inside {[9'd248:9'd250]})
		else $error("mid tick period wrong");
	slow_period_a: assert property (mf_32k_tick_o && ms_seen_r |-> ms_gap_r inside {[13'd3904:13'd3907]})
		else $error("slow mid tick period wrong");
	pin_toggle_a: assert property (sys_clk_en_o |=> $changed(clock_output_pin_o))
		else $error("output pin missed a toggle");
	pin_hold_a: assert property (!sys_clk_en_o |=> $stable(clock_output_pin_o))
		else $error("output pin toggled without enable");
endmodule // osc_ctrl_props
bind osc_ctrl osc_ctrl_props osc_ctrl_props_i (.clk_sys_i, .rstn_i, .clock_output_enable_cfg_i,
	.psel_i, .penable_i, .pready_o, .pslverr_o, .sys_clk_en_o, .lf_tick_o, .mf_500k_tick_o,
	.mf_32k_tick_o, .clock_input_pin_release_o, .clock_output_pin_o, .clock_output_pin_oe_o);
